// [hw/amp_irq_pkg.sv]
// Constants for the amplifier event and interrupt-request controller.
// Assumes a byte-wide internal register port on a 16-bit address.
package amp_irq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Source layout: four banks of eight event sources
  localparam int unsigned BANKS  = 4;
  localparam int unsigned BANK_W = 8;
  localparam int unsigned SRC_N  = 32;

  // Bank 0 thermal/fault, 1 monitors, 2 supply/power, 3 brownout
  localparam logic [31:0] SRC_VALID      = 32'h0fff_f7ff;
  localparam logic [31:0] MASK_RESET     = 32'h0000_0002;
  localparam logic [31:0] RAW_PREV_RESET = 32'hffff_ffff;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [15:0] OFS_MASK_FIRST  = 16'h2010;
  localparam logic [15:0] OFS_CLEAR_FIRST = 16'h2015;
  localparam logic [15:0] OFS_MASK_SUPPLY_POWER      = 16'h2012;
  localparam logic [15:0] OFS_MASK_BROWNOUT          = 16'h2013;
  localparam logic [15:0] OFS_CLEAR_THERMAL_FAULT    = 16'h2015;
  localparam logic [15:0] OFS_CLEAR_MONITORS         = 16'h2016;
  localparam logic [15:0] OFS_CLEAR_SUPPLY_POWER     = 16'h2017;
  localparam logic [15:0] OFS_CLEAR_BROWNOUT         = 16'h2018;
  localparam logic [15:0] OFS_REQUEST_PIN_CONTROL    = 16'h201f;
  localparam logic [15:0] OFS_THERMAL_WARNING_ONE    = 16'h2020;
  localparam logic [15:0] OFS_THERMAL_WARNING_TWO    = 16'h2021;

  ////////////////////////////////////////////////////////////////////////////
  // Request pin control fields
  localparam int unsigned PIN_ENABLE_BIT   = 0;
  localparam int unsigned PIN_POLARITY_BIT = 1;
  localparam int unsigned PIN_MODE_BIT     = 2;
  localparam logic [2:0]  PIN_CONTROL_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Thermal warning levels
  localparam logic [6:0] WARN_ONE_RESET = 7'h46;
  localparam logic [6:0] WARN_TWO_RESET = 7'h52;
  localparam logic [6:0] LEVEL_SAT_CODE = 7'h64;
  localparam logic [7:0] LEVEL_BASE_DEG = 8'h32;
  localparam logic [7:0] LEVEL_MAX_DEG  = 8'h96;

endpackage

// [hw/irq_core_if.sv]
// Carrier between the register front end, the sticky event bank and the
// request pin driver. All members live on the single system clock.
`timescale 1ns/1ps
`default_nettype none
interface irq_core_if #(
  parameter int unsigned N = 32
);
  logic [N-1:0] raw;
  logic [N-1:0] mask;
  logic [N-1:0] clr;
  logic [N-1:0] flag;
  logic         pin_en;
  logic         pin_pol;
  logic         pin_mode;
  logic         pin_level;
  logic         pin_oen;

  modport ctrl (output raw, output mask, output clr, output pin_en, output pin_pol,
                output pin_mode, input flag, input pin_level, input pin_oen);
  modport bank (input raw, input mask, input clr, output flag);
  modport pin  (input flag, input pin_en, input pin_pol, input pin_mode,
                output pin_level, output pin_oen);
endinterface
`default_nettype wire

// [hw/event_sticky_bank.sv]
// Sticky edge capture and masked flags for every event source.
// Assumes raw events are synchronous to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module event_sticky_bank (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  irq_core_if.bank  evt
);

  logic [amp_irq_pkg::SRC_N-1:0] raw_prev_ff;
  logic [amp_irq_pkg::SRC_N-1:0] sticky_ff;
  logic [amp_irq_pkg::SRC_N-1:0] flag_ff;

  assign evt.flag = flag_ff;

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < amp_irq_pkg::SRC_N; i++) begin : g_src
    logic rise;
    logic nxt_sticky;

    assign rise       = evt.raw[i] & ~raw_prev_ff[i] & amp_irq_pkg::SRC_VALID[i];
    // Set wins over a clear in the same cycle
    assign nxt_sticky = rise | (sticky_ff[i] & ~evt.clr[i]); // see R3 see R4 see R19

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        raw_prev_ff[i] <= amp_irq_pkg::RAW_PREV_RESET[i];
      end else begin
        raw_prev_ff[i] <= evt.raw[i];
      end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        sticky_ff[i] <= 1'b0;
        flag_ff[i]   <= 1'b0;
      end else begin
        sticky_ff[i] <= nxt_sticky;
        flag_ff[i]   <= nxt_sticky & evt.mask[i]; // see R1 see R2 see R19
      end
    end

    AST_RISE_SETS_FLAG: assert property ( // see R2
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (rise && evt.mask[i]) |=> flag_ff[i])
      else $error("flag missed an enabled rising edge");

    AST_ZERO_CLEAR_KEEPS: assert property ( // see R4
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (sticky_ff[i] && !evt.clr[i]) |=> sticky_ff[i])
      else $error("sticky bit lost without a clear");

    AST_CLEAR_EMPTIES: assert property ( // see R3
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (evt.clr[i] && !rise) |=> (!sticky_ff[i] && !flag_ff[i]))
      else $error("clear left sticky or flag set");
  end

  AST_MASK_HOLDS_LOW: assert property ( // see R1
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ##1 1'b1 |-> ((flag_ff & ~$past(evt.mask)) == '0))
    else $error("masked source shows a flag");

endmodule
`default_nettype wire

// [hw/irq_pin_driver.sv]
// Request pin: polarity, open-drain or push-pull, and re-edge on new flags.
// Assumes flags come from flip-flops on the same clock.
`timescale 1ns/1ps
`default_nettype none
module irq_pin_driver (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  irq_core_if.pin   pin
);

  logic [amp_irq_pkg::SRC_N-1:0] flag_prev_ff;
  logic                          asserted_ff;
  logic                          level_ff;
  logic                          oen_ff;
  logic                          new_rise;
  logic                          nxt_asserted;
  logic                          nxt_level;

  assign new_rise     = |(pin.flag & ~flag_prev_ff);
  // Release for one cycle so every new flag gives a fresh edge
  assign nxt_asserted = (|pin.flag) & ~(new_rise & asserted_ff); // see R18 see R12
  assign nxt_level    = ~(nxt_asserted ^ pin.pin_pol); // see R13 see R14
  assign pin.pin_level = level_ff;
  assign pin.pin_oen   = oen_ff;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_prev_ff <= '0;
      asserted_ff  <= 1'b0;
    end else begin
      flag_prev_ff <= pin.flag;
      asserted_ff  <= nxt_asserted;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_ff <= 1'b0;
      oen_ff   <= 1'b1;
    end else begin
      level_ff <= pin.pin_mode ? nxt_level : 1'b0; // see R15
      oen_ff   <= ~pin.pin_en | (~pin.pin_mode & nxt_level); // see R11 see R15
    end
  end

  sequence seq_steady_request(logic pol);
    (pin.pin_en && pin.pin_mode && pin.pin_pol == pol && |pin.flag && !new_rise
     && asserted_ff) [*2];
  endsequence

  AST_PIN_HIZ: assert property ( // see R11
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !pin.pin_en |=> oen_ff)
    else $error("pin driven while disabled");

  AST_ACTIVE_LOW: assert property ( // see R13
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    seq_steady_request(1'b0) |=> (!level_ff && !oen_ff))
    else $error("active-low request not low");

  AST_ACTIVE_HIGH: assert property ( // see R14
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    seq_steady_request(1'b1) |=> (level_ff && !oen_ff))
    else $error("active-high request not high");

  AST_OPEN_DRAIN_LOW_ONLY: assert property ( // see R15
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (pin.pin_en && !pin.pin_mode) |=> !level_ff)
    else $error("open-drain pin drove high");

  AST_NEW_FLAG_REEDGE: assert property ( // see R18
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (asserted_ff && new_rise) |=> !asserted_ff ##1 asserted_ff)
    else $error("new flag gave no fresh request edge");

endmodule
`default_nettype wire

// [hw/amp_event_irq_controller.sv]
// Top of the amplifier event and interrupt-request controller.
// Assumes the control port front end presents byte register accesses
// synchronous to clk_sys_i, and raw events from core logic on that clock.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: Disabled source never shows its flag.
// R2: Enabled source flags after a raw rising edge.
// R3: Writing one clears sticky and flag.
// R4: Writing zero clears nothing; clears are write-only.
// R5: Supply/power mask register bit assignment.
// R6: Brownout mask uses bits 3..0 only.
// R7: First clear register clears thermal/fault events.
// R8: Second clear register clears monitors; bit 3 unused.
// R9: Third clear register mirrors supply/power masks.
// R10: Fourth clear register clears brownout bits 3..0.
// R11: Pin enable zero leaves request pin floating.
// R12: Pin enabled follows combined flags.
// R13: Polarity zero asserts low.
// R14: Polarity one asserts high.
// R15: Mode zero open-drain, one push-pull; board pulls up.
// R16: Warning one level: 50 plus code, saturates 150.
// R17: Warning two level: same encoding, reset 0x52.
// R18: Each new flag rising edge signals a request.
// R19: Edges latch regardless of mask; clears read zero.
module amp_event_irq_controller (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o,
  input  wire logic [31:0] event_raw_i,
  output logic      [31:0] event_flag_o,
  output logic      [6:0]  heat_warning_one_level_o,
  output logic      [6:0]  heat_warning_two_level_o,
  output logic      [7:0]  heat_warning_one_deg_o,
  output logic      [7:0]  heat_warning_two_deg_o,
  output logic             irq_pin_o,
  output logic             irq_pin_oen_o
);

  logic [31:0] mask_ff;
  logic [31:0] clr_ff;
  logic [2:0]  pin_control_ff;
  logic [6:0]  warn_one_ff;
  logic [6:0]  warn_two_ff;
  logic [7:0]  deg_one_ff;
  logic [7:0]  deg_two_ff;
  logic [7:0]  rdata_ff;
  logic        rvalid_ff;
  logic [7:0]  nxt_rdata;

  irq_core_if #(.N(amp_irq_pkg::SRC_N)) core ();

  ////////////////////////////////////////////////////////////////////////////
  // Code to degrees, saturating
  function automatic logic [7:0] level_to_deg(input logic [6:0] code);
    logic [7:0] deg;
    deg = amp_irq_pkg::LEVEL_MAX_DEG;
    if (code < amp_irq_pkg::LEVEL_SAT_CODE) begin
      deg = amp_irq_pkg::LEVEL_BASE_DEG + {1'b0, code};
    end
    return deg;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Mask registers, one byte per bank
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_ff <= amp_irq_pkg::MASK_RESET;
    end else begin
      for (int b = 0; b < amp_irq_pkg::BANKS; b++) begin
        if (reg_wr_i && reg_addr_i == 16'(amp_irq_pkg::OFS_MASK_FIRST + b)) begin
          mask_ff[b*8 +: 8] <= reg_wdata_i & amp_irq_pkg::SRC_VALID[b*8 +: 8]; // see R5 see R6
        end
      end
    end
  end

  // One-cycle clear strobes from the write-only clear registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clr_ff <= '0;
    end else begin
      for (int b = 0; b < amp_irq_pkg::BANKS; b++) begin
        if (reg_wr_i && reg_addr_i == 16'(amp_irq_pkg::OFS_CLEAR_FIRST + b)) begin
          clr_ff[b*8 +: 8] <= reg_wdata_i & amp_irq_pkg::SRC_VALID[b*8 +: 8]; // see R7 see R8 see R9 see R10
        end else begin
          clr_ff[b*8 +: 8] <= 8'h00; // see R4
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin control and thermal warning levels
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_control_ff <= amp_irq_pkg::PIN_CONTROL_RESET;
    end else if (reg_wr_i && reg_addr_i == amp_irq_pkg::OFS_REQUEST_PIN_CONTROL) begin
      pin_control_ff <= reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warn_one_ff <= amp_irq_pkg::WARN_ONE_RESET; // see R16
      warn_two_ff <= amp_irq_pkg::WARN_TWO_RESET; // see R17
    end else begin
      if (reg_wr_i && reg_addr_i == amp_irq_pkg::OFS_THERMAL_WARNING_ONE) begin
        warn_one_ff <= reg_wdata_i[6:0];
      end
      if (reg_wr_i && reg_addr_i == amp_irq_pkg::OFS_THERMAL_WARNING_TWO) begin
        warn_two_ff <= reg_wdata_i[6:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      deg_one_ff <= amp_irq_pkg::LEVEL_MAX_DEG;
      deg_two_ff <= amp_irq_pkg::LEVEL_MAX_DEG;
    end else begin
      deg_one_ff <= level_to_deg(warn_one_ff); // see R16
      deg_two_ff <= level_to_deg(warn_two_ff); // see R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; clear registers and unmapped offsets read zero
  always_comb begin
    nxt_rdata = 8'h00; // see R19
    for (int b = 0; b < amp_irq_pkg::BANKS; b++) begin
      if (reg_addr_i == 16'(amp_irq_pkg::OFS_MASK_FIRST + b)) begin
        nxt_rdata = mask_ff[b*8 +: 8];
      end
    end
    if (reg_addr_i == amp_irq_pkg::OFS_REQUEST_PIN_CONTROL) begin
      nxt_rdata = {5'h00, pin_control_ff};
    end
    if (reg_addr_i == amp_irq_pkg::OFS_THERMAL_WARNING_ONE) begin
      nxt_rdata = {1'b0, warn_one_ff};
    end
    if (reg_addr_i == amp_irq_pkg::OFS_THERMAL_WARNING_TWO) begin
      nxt_rdata = {1'b0, warn_two_ff};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core wiring
  assign core.raw      = event_raw_i;
  assign core.mask     = mask_ff;
  assign core.clr      = clr_ff;
  assign core.pin_en   = pin_control_ff[amp_irq_pkg::PIN_ENABLE_BIT];
  assign core.pin_pol  = pin_control_ff[amp_irq_pkg::PIN_POLARITY_BIT];
  assign core.pin_mode = pin_control_ff[amp_irq_pkg::PIN_MODE_BIT];

  event_sticky_bank u_bank (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .evt       (core.bank)
  );

  irq_pin_driver u_pin (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin       (core.pin)
  );

  assign reg_rdata_o              = rdata_ff;
  assign reg_rvalid_o             = rvalid_ff;
  assign event_flag_o             = core.flag;
  assign heat_warning_one_level_o = warn_one_ff;
  assign heat_warning_two_level_o = warn_two_ff;
  assign heat_warning_one_deg_o   = deg_one_ff;
  assign heat_warning_two_deg_o   = deg_two_ff;
  assign irq_pin_o                = core.pin_level;
  assign irq_pin_oen_o            = core.pin_oen;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seq_write(logic [15:0] ofs);
    reg_wr_i && reg_addr_i == ofs;
  endsequence

  AST_SUPPLY_MASK_WRITE: assert property ( // see R5
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    seq_write(amp_irq_pkg::OFS_MASK_SUPPLY_POWER) |=> mask_ff[23:16] == $past(reg_wdata_i))
    else $error("supply mask did not take the written byte");

  AST_BROWNOUT_UPPER_ZERO: assert property ( // see R6
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    seq_write(amp_irq_pkg::OFS_MASK_BROWNOUT) |=> mask_ff[31:28] == 4'h0)
    else $error("brownout mask upper nibble set");

  AST_THERMAL_CLEAR_PULSE: assert property ( // see R7
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    seq_write(amp_irq_pkg::OFS_CLEAR_THERMAL_FAULT) |=>
      clr_ff[7:0] == $past(reg_wdata_i) ##1 (clr_ff[7:0] == 8'h00 || $past(reg_wr_i)))
    else $error("thermal clear strobe wrong");

  AST_MONITOR_CLEAR_BIT3: assert property ( // see R8
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    seq_write(amp_irq_pkg::OFS_CLEAR_MONITORS) |=>
      clr_ff[15:8] == ($past(reg_wdata_i) & 8'hf7))
    else $error("monitor clear strobe wrong");

  AST_SUPPLY_CLEAR_FLAGS: assert property ( // see R9
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (seq_write(amp_irq_pkg::OFS_CLEAR_SUPPLY_POWER) ##1 (event_raw_i[23:16] == 8'h00))
      |=> (event_flag_o[23:16] & $past(reg_wdata_i, 2)) == 8'h00)
    else $error("supply clear left a flag set");

  AST_BROWNOUT_CLEAR_LOW: assert property ( // see R10
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    seq_write(amp_irq_pkg::OFS_CLEAR_BROWNOUT) |=> clr_ff[31:28] == 4'h0)
    else $error("brownout clear touched unused bits");

  AST_CLEAR_READS_ZERO: assert property ( // see R4 see R19
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i >= amp_irq_pkg::OFS_CLEAR_THERMAL_FAULT
      && reg_addr_i <= amp_irq_pkg::OFS_CLEAR_BROWNOUT) |=> (rvalid_ff && rdata_ff == 8'h00))
    else $error("clear register read not zero");

  AST_WARN_ONE_SAT: assert property ( // see R16
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (warn_one_ff >= amp_irq_pkg::LEVEL_SAT_CODE) |=> deg_one_ff == amp_irq_pkg::LEVEL_MAX_DEG)
    else $error("warning one did not saturate");

  AST_WARN_TWO_LINEAR: assert property ( // see R17
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (warn_two_ff < amp_irq_pkg::LEVEL_SAT_CODE) |=>
      deg_two_ff == 8'h32 + {1'b0, $past(warn_two_ff)})
    else $error("warning two degrees wrong");

  AST_PIN_FOLLOWS_FLAGS: assert property ( // see R12
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (core.pin_en && core.pin_mode && event_flag_o == '0) [*2] |=>
      (irq_pin_o == ~$past(core.pin_pol) && !irq_pin_oen_o))
    else $error("idle request pin not at idle level");

endmodule
`default_nettype wire

// [testbench/host_irq_receiver.sv]
// Host side of the request pin: board pull-up and edge counting.
// Assumes the pin output enable is active low and both inputs share clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module host_irq_receiver (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       pin_i,
  input  wire logic       pin_oen_n_i,
  output logic            level_o,
  output logic [7:0]      edge_count_o
);
  logic prev_ff;

  // Released line floats up to the board pull-up
  assign level_o = pin_oen_n_i ? 1'b1 : pin_i;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_ff      <= 1'b1;
      edge_count_o <= 8'h00;
    end else begin
      prev_ff <= level_o;
      if (level_o && !prev_ff) begin
        edge_count_o <= edge_count_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/amp_event_irq_controller_tb.sv]
// Self-checking bench for the event and interrupt-request controller.
// Assumes the design files and host_irq_receiver are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module amp_event_irq_controller_tb;
  logic        clk_sys_i;
  logic        rst_n_i;
  logic [15:0] reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [31:0] raw;
  logic [31:0] flag;
  logic [6:0]  lvl_one;
  logic [6:0]  lvl_two;
  logic [7:0]  deg_one;
  logic [7:0]  deg_two;
  logic        pin;
  logic        pin_oen_n;
  logic        wire_level;
  logic [7:0]  edges;
  int          bad_count;
  int          tests_run;

  amp_event_irq_controller DUT (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .reg_rvalid_o(reg_rvalid), .event_raw_i(raw), .event_flag_o(flag),
    .heat_warning_one_level_o(lvl_one), .heat_warning_two_level_o(lvl_two),
    .heat_warning_one_deg_o(deg_one), .heat_warning_two_deg_o(deg_two),
    .irq_pin_o(pin), .irq_pin_oen_o(pin_oen_n));

  host_irq_receiver host (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .pin_i(pin), .pin_oen_n_i(pin_oen_n),
    .level_o(wire_level), .edge_count_o(edges));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr    <= 1'b0;
  endtask

  task automatic check_reg(input logic [15:0] a, input logic [7:0] exp);
    int i;
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd   <= 1'b0;
    #1;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) cycles(1);
    if (reg_rvalid !== 1'b1) begin
      bad_count++;
      $display("mismatch read valid at %h expected 1 seen %b", a, reg_rvalid);
      end_of_test();
    end
    check_byte("register read", exp, reg_rdata);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_and_levels();
    logic [15:0] a[10] = '{16'h2012, 16'h2013, 16'h2015, 16'h2016, 16'h2017, 16'h2018,
                           16'h201f, 16'h2020, 16'h2021, 16'h2019};
    logic [7:0]  e[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h46, 8'h52,
                           8'h00};
    foreach (a[i]) check_reg(a[i], e[i]);
    check_byte("level one", 8'h46, {1'b0, lvl_one});
    check_byte("level two", 8'h52, {1'b0, lvl_two});
    check_byte("deg one", 8'h78, deg_one);
    check_byte("deg two", 8'h84, deg_two);
    write_reg(16'h2020, 8'h63);
    write_reg(16'h2021, 8'hff);
    cycles(3);
    check_byte("deg one", 8'h95, deg_one);
    check_byte("deg two", 8'h96, deg_two);
    check_reg(16'h2021, 8'h7f);
    check_byte("level two", 8'h7f, {1'b0, lvl_two});
    write_reg(16'h2020, 8'h64);
    cycles(3);
    check_byte("deg one", 8'h96, deg_one);
    check_byte("level one", 8'h64, {1'b0, lvl_one});
  endtask

  task automatic test_mask_gate();
    write_reg(16'h2012, 8'h7f);
    write_reg(16'h2013, 8'hff);
    check_reg(16'h2013, 8'h0f);
    @(posedge clk_sys_i);
    raw <= 32'h00c0_0000;
    cycles(3);
    check_word("flags masked", 32'h0040_0000, flag);
    write_reg(16'h2012, 8'hff);
    cycles(3);
    check_word("flags unmasked", 32'h00c0_0000, flag);
    check_reg(16'h2012, 8'hff);
    write_reg(16'h2017, 8'hc0);
    raw <= 32'h0;
    cycles(3);
    check_word("flags cleared", 32'h0, flag);
  endtask

  task automatic test_clears();
    logic [31:0] exp;
    for (int b = 0; b < 4; b++) begin
      write_reg(16'h2010 + 16'(b), 8'hff);
      raw <= 32'hff << (8 * b);
      exp = amp_irq_pkg::SRC_VALID & (32'hff << (8 * b));
      cycles(3);
      check_word("bank flags", exp, flag);
      write_reg(16'h2015 + 16'(b), 8'h00);
      cycles(3);
      check_word("zero clear", exp, flag);
      write_reg(16'h2015 + 16'(b), 8'h01);
      cycles(3);
      check_word("one bit clear", exp & ~(32'h1 << (8 * b)), flag);
      write_reg(16'h2015 + 16'(b), 8'hff);
      cycles(3);
      check_word("bank clear", 32'h0, flag);
      @(posedge clk_sys_i);
      raw <= 32'h0;
      write_reg(16'h2010 + 16'(b), 8'h00);
    end
  endtask

  task automatic test_pin_modes();
    logic oen_e;
    logic lvl;
    write_reg(16'h2013, 8'h01);
    for (int c = 0; c < 8; c++) begin
      write_reg(16'h201f, 8'(c));
      for (int act = 1; act >= 0; act--) begin
        @(posedge clk_sys_i);
        raw <= act ? 32'h0100_0000 : 32'h0;
        if (act == 0) write_reg(16'h2018, 8'h01);
        cycles(4);
        lvl   = (act == 1) ? c[1] : ~c[1];
        oen_e = !c[0] ? 1'b1 : (c[2] ? 1'b0 : lvl);
        check_byte("pin oen", {7'h0, oen_e}, {7'h0, pin_oen_n});
        check_byte("pin wire", {7'h0, c[0] ? lvl : 1'b1}, {7'h0, wire_level});
      end
    end
  endtask

  task automatic test_reedge();
    logic [7:0] base;
    write_reg(16'h201f, 8'h07);
    write_reg(16'h2013, 8'h03);
    cycles(3);
    base = edges;
    @(posedge clk_sys_i);
    raw <= 32'h0100_0000;
    cycles(4);
    @(posedge clk_sys_i);
    raw <= 32'h0300_0000;
    cycles(5);
    check_byte("request edges", base + 8'h02, edges);
    check_byte("pin held", 8'h01, {7'h0, wire_level});
    write_reg(16'h2018, 8'h03);
    raw <= 32'h0;
    cycles(4);
    check_byte("pin idle", 8'h00, {7'h0, wire_level});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #500000;
    bad_count++;
    $display("mismatch run time expected done seen hung");
    end_of_test();
  end

  initial begin
    bad_count = 0;
    tests_run = 0;
    rst_n_i   = 1'b0;
    reg_addr  = 16'h0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
    raw       = 32'h0;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    cycles(2);
    test_reset_and_levels();
    test_mask_gate();
    test_clears();
    test_pin_modes();
    test_reedge();
    end_of_test();
  end
endmodule
`default_nettype wire
